// [rtl/rss_pkg.sv]
package rss_pkg;

	localparam int RSS_CLOCK_HZ = 20000000;
	localparam int RSS_SLOT_US = 625;
	localparam int RSS_SLOT_US_LONG = 10500;
	localparam int RSS_RESET_DELAY_MS = 16;
	localparam int RSS_SLOT_CYCLES = (RSS_SLOT_US * (RSS_CLOCK_HZ / 1000000));
	localparam int RSS_NUM_RAILS = 12;
	localparam int RSS_NUM_OUT = 13;
	localparam int RSS_CNT_W = 24;
	localparam int RSS_SLOT_W = 4;
	// Last slot used by each preset table; a sequence ends there
	localparam logic [3:0] RSS_UP_LAST = 4'h6;
	localparam logic [3:0] RSS_DOWN_LAST = 4'h5;
	localparam logic [3:0] RSS_EXIT_LAST = 4'h4;
	localparam logic [3:0] RSS_ENTRY_LAST = 4'h3;

	// Register offsets
	localparam logic [7:0] RSS_ADDR_FLAGS_A = 8'h00;
	localparam logic [7:0] RSS_ADDR_FLAGS_B = 8'h01;
	localparam logic [7:0] RSS_ADDR_IRQ_EN = 8'h02;
	localparam logic [7:0] RSS_ADDR_STATUS = 8'h03;
	localparam logic [7:0] RSS_ADDR_CONFIG = 8'h04;
	localparam logic [7:0] RSS_IRQ_EN_RESET = 8'hff;
	localparam logic [7:0] RSS_CONFIG_RESET = 8'h01;
	localparam logic [7:0] RSS_CHECK_INIT = 8'h00;

	// Bits of fault_flags_a
	localparam int RSS_FA_RESET_PULLED = 0;
	localparam int RSS_FA_EMERGENCY = 1;
	// Bits of fault_flags_b
	localparam int RSS_FB_BAD_CHECK = 0;
	localparam int RSS_FB_EXTRA_BYTE = 1;

	// Slot tables, index 0 is enable 1, index 12 is the slow clock enable
	localparam logic [RSS_NUM_OUT*4-1:0] RSS_UP_SLOTS =
		{4'h4, 4'h0, 4'h4, 4'h0, 4'h4, 4'h2, 4'h1, 4'h6, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1};
	localparam logic [RSS_NUM_OUT*4-1:0] RSS_DOWN_SLOTS =
		{4'h4, 4'h0, 4'h2, 4'h0, 4'h2, 4'h4, 4'h1, 4'h1, 4'h2, 4'h4, 4'h4, 4'h1, 4'h5};
	localparam logic [RSS_NUM_OUT*4-1:0] RSS_EXIT_SLOTS =
		{4'h0, 4'h0, 4'h1, 4'h0, 4'h4, 4'h3, 4'h1, 4'h2, 4'h0, 4'h0, 4'h3, 4'h1, 4'h0};
	localparam logic [RSS_NUM_OUT*4-1:0] RSS_ENTRY_SLOTS =
		{4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h2, 4'h3, 4'h1, 4'h0, 4'h0, 4'h2, 4'h3, 4'h0};

	typedef enum logic [4:0] {
		RSS_SHUTDOWN = 5'h01,
		RSS_POWER_UP = 5'h02,
		RSS_ACTIVE = 5'h04,
		RSS_POWER_DOWN = 5'h08,
		RSS_SLEEP_SEQ = 5'h10
	} rss_state_type;

endpackage

// [rtl/rss_sequencer.sv]
`timescale 1ns/1ns
// Summary of operation
// - Activate high starts power-up, active mode
// - Activate low starts power-down, shutdown mode
// - Flags cleared only by host write-one
// - Flags stay until cleared, interrupt until cleared or masked in irq_en_r
// - Interrupt asserted while any flag set whose irq_en_r bit is set
// - Sleep low runs sleep-entry on sleep enables
// - Sleep high runs sleep-exit on sleep enables
// - Emergency low immediately starts power-down
// - Check byte computation starts from zero
// - Bad check flags at start of next transaction
// - Byte after good check discards write
// - Slot 1 enables follow activate at once
// - Slot 2 one slot period after slot 1
// - Sleep slots spaced by slot period
// - Preset power-up and power-down slot tables
// - Preset sleep-exit and sleep-entry slot tables
// - Slot period and delays fixed per variant
// - External reset pull-low is a fault
module rss_sequencer
	import rss_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Mode pins
	input wire logic activate_in,
	input wire logic sleep_in,
	input wire logic emergency_powerdown_n,
	input wire logic system_reset_n,
	// Host register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Host bus byte stream, already framed
	input wire logic bus_start,
	input wire logic bus_byte_valid,
	input wire logic [7:0] bus_byte,
	input wire logic bus_byte_is_check,
	input wire logic bus_stop,
	output logic bus_write_ok,
	// Rail enables, index 12 is the slow clock enable
	output logic [RSS_NUM_OUT-1:0] enable_out,
	output logic shutdown_mode,
	output logic sleep_mode,
	// Open-drain interrupt, drive low when oe is low
	output logic fault_irq_n_out,
	output logic fault_irq_n_oe_n
);

	rss_state_type state_r;
	logic [RSS_CNT_W-1:0] tick_r;
	logic [RSS_SLOT_W-1:0] slot_r;
	logic act_r, sleep_r, em_r, system_reset_n_r;
	logic [RSS_NUM_OUT-1:0] power_r, sleep_gate_r;
	logic seq_sleep_exit_r;
	logic [7:0] flags_a_r, flags_b_r, irq_en_r, config_r;
	logic [7:0] crc_r, crc_nxt;
	logic check_bad_r, check_good_r, extra_r, pend_bad_r;
	logic slot_tick, start_up, start_down, start_sleep, start_wake;
	logic set_reset_pulled, set_emergency, set_bad, set_extra;
	logic irq;

	// Edge detection of the mode pins
	always_ff @(posedge clock) begin
		if (!resetn) begin
			act_r <= 1'b0;
			sleep_r <= 1'b1;
			em_r <= 1'b1;
			system_reset_n_r <= 1'b1;
		end else begin
			act_r <= activate_in;
			sleep_r <= sleep_in;
			em_r <= emergency_powerdown_n;
			system_reset_n_r <= system_reset_n;
		end
	end

	assign start_up = activate_in && !act_r && emergency_powerdown_n;
	assign start_down = (!activate_in && act_r) || (!emergency_powerdown_n && em_r);
	assign start_sleep = !sleep_in && sleep_r
		&& (state_r == RSS_ACTIVE || state_r == RSS_SLEEP_SEQ);
	assign start_wake = sleep_in && !sleep_r
		&& (state_r == RSS_ACTIVE || state_r == RSS_SLEEP_SEQ);
	assign slot_tick = (tick_r == RSS_CNT_W'(RSS_SLOT_CYCLES - 1));

	// Sequence state machine; power-down has priority except in RSS_POWER_DOWN, where start_up is checked first
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_r <= RSS_SHUTDOWN;
			tick_r <= '0;
			slot_r <= '0;
			seq_sleep_exit_r <= 1'b0;
		end else begin
			tick_r <= (start_up || start_down || start_sleep || start_wake || slot_tick) ?
				'0 : tick_r + 1'b1;
			if (slot_tick)
				slot_r <= slot_r + 1'b1;
			case (state_r)
				RSS_SHUTDOWN, RSS_ACTIVE: begin
					if (start_down) begin
						state_r <= RSS_POWER_DOWN;
						slot_r <= 4'h1;
					end else if (start_up) begin
						state_r <= RSS_POWER_UP;
						slot_r <= 4'h1;
					end else if (start_sleep || start_wake) begin
						state_r <= RSS_SLEEP_SEQ;
						seq_sleep_exit_r <= start_wake;
						slot_r <= 4'h1;
					end
				end
				// A sequence ends in the first cycle of its last slot, on the same
				// edge at which that slot acts, so no idle slots are appended
				RSS_POWER_UP: begin
					if (start_down) begin
						state_r <= RSS_POWER_DOWN;
						slot_r <= 4'h1;
					end else if (slot_r == RSS_UP_LAST && tick_r == '0)
						state_r <= RSS_ACTIVE;
				end
				RSS_SLEEP_SEQ: begin
					if (start_down) begin
						state_r <= RSS_POWER_DOWN;
						slot_r <= 4'h1;
					end else if (start_sleep || start_wake) begin
						// A pin change mid-sequence reverses it from its first slot
						seq_sleep_exit_r <= start_wake;
						slot_r <= 4'h1;
					end else if (tick_r == '0 && slot_r == (seq_sleep_exit_r ?
						RSS_EXIT_LAST : RSS_ENTRY_LAST))
						state_r <= RSS_ACTIVE;
				end
				RSS_POWER_DOWN: begin
					if (start_up) begin
						state_r <= RSS_POWER_UP;
						slot_r <= 4'h1;
					end else if (start_down)
						slot_r <= 4'h1;
					else if (slot_r == RSS_DOWN_LAST && tick_r == '0)
						state_r <= RSS_SHUTDOWN;
				end
				default: state_r <= RSS_SHUTDOWN;
			endcase
		end
	end

	// One generate loop drives every enable from its slot entries
	genvar g;
	generate
		for (g = 0; g < RSS_NUM_OUT; g++) begin : g_rail
			localparam logic [3:0] UP = RSS_UP_SLOTS[g*4 +: 4];
			localparam logic [3:0] DN = RSS_DOWN_SLOTS[g*4 +: 4];
			localparam logic [3:0] EX = RSS_EXIT_SLOTS[g*4 +: 4];
			localparam logic [3:0] EN = RSS_ENTRY_SLOTS[g*4 +: 4];
			// Slot N fires when slot counter equals N; power-up slot 1 also on the trigger edge
			always_ff @(posedge clock) begin
				if (!resetn) begin
					power_r[g] <= 1'b0;
					sleep_gate_r[g] <= 1'b1;
				end else if ((state_r == RSS_POWER_UP && UP != 4'h0 && slot_r == UP)
					|| (UP == 4'h1 && start_up)) begin
					// Slot 1 latches on the trigger edge so the rail never dips
					power_r[g] <= 1'b1;
					sleep_gate_r[g] <= 1'b1;
				end else if (state_r == RSS_POWER_DOWN && DN != 4'h0 && slot_r == DN) begin
					power_r[g] <= 1'b0;
				end else if (state_r == RSS_SLEEP_SEQ && !seq_sleep_exit_r && EN != 4'h0
					&& slot_r == EN) begin
					sleep_gate_r[g] <= 1'b0;
				end else if (state_r == RSS_SLEEP_SEQ && seq_sleep_exit_r && EX != 4'h0
					&& slot_r == EX) begin
					sleep_gate_r[g] <= 1'b1;
				end
			end
			// Slot 1 rails rise combinationally with activate for zero added delay
			assign enable_out[g] = (power_r[g] && sleep_gate_r[g])
				|| (UP == 4'h1 && start_up);
		end
	endgenerate

	assign shutdown_mode = (state_r == RSS_SHUTDOWN) || (state_r == RSS_POWER_DOWN);
	assign sleep_mode = (state_r == RSS_ACTIVE || state_r == RSS_SLEEP_SEQ) && !sleep_r;

	// Packet check byte, CRC-8 poly 0x07, restarted at every bus start
	always_comb begin
		crc_nxt = crc_r ^ bus_byte;
		for (int i = 0; i < 8; i++)
			crc_nxt = crc_nxt[7] ? ((crc_nxt << 1) ^ 8'h07) : (crc_nxt << 1);
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			crc_r <= RSS_CHECK_INIT;
			check_bad_r <= 1'b0;
			check_good_r <= 1'b0;
			extra_r <= 1'b0;
			pend_bad_r <= 1'b0;
		end else begin
			if (bus_start) begin
				crc_r <= RSS_CHECK_INIT;
				check_good_r <= 1'b0;
				extra_r <= 1'b0;
				check_bad_r <= 1'b0;
			end else if (bus_byte_valid && config_r[0]) begin
				if (check_good_r)
					extra_r <= 1'b1;
				else if (bus_byte_is_check) begin
					check_good_r <= (bus_byte == crc_r);
					check_bad_r <= (bus_byte != crc_r);
				end else
					crc_r <= crc_nxt;
			end
			// A bad check is only reported once the next transaction starts
			if (bus_stop && check_bad_r)
				pend_bad_r <= 1'b1;
			else if (bus_start)
				pend_bad_r <= 1'b0;
		end
	end

	assign set_bad = bus_start && pend_bad_r;
	assign set_extra = bus_stop && extra_r;
	assign bus_write_ok = bus_stop && !extra_r && !check_bad_r;
	assign set_reset_pulled = !system_reset_n && system_reset_n_r;
	assign set_emergency = !emergency_powerdown_n && em_r;

	// Sticky flags: set beats a same-cycle write-one clear
	always_ff @(posedge clock) begin
		if (!resetn) begin
			flags_a_r <= '0;
			flags_b_r <= '0;
		end else begin
			flags_a_r <= (flags_a_r & ~((reg_write && reg_addr == RSS_ADDR_FLAGS_A) ?
				reg_wdata : 8'h00))
				| {6'h00, set_emergency, set_reset_pulled};
			flags_b_r <= (flags_b_r & ~((reg_write && reg_addr == RSS_ADDR_FLAGS_B) ?
				reg_wdata : 8'h00))
				| {6'h00, set_extra, set_bad};
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			irq_en_r <= RSS_IRQ_EN_RESET;
			config_r <= RSS_CONFIG_RESET;
		end else if (reg_write) begin
			if (reg_addr == RSS_ADDR_IRQ_EN)
				irq_en_r <= reg_wdata;
			if (reg_addr == RSS_ADDR_CONFIG)
				config_r <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			reg_rdata <= '0;
		else if (reg_read) begin
			case (reg_addr)
				RSS_ADDR_FLAGS_A: reg_rdata <= flags_a_r;
				RSS_ADDR_FLAGS_B: reg_rdata <= flags_b_r;
				RSS_ADDR_IRQ_EN: reg_rdata <= irq_en_r;
				RSS_ADDR_STATUS: reg_rdata <= {3'h0, state_r};
				RSS_ADDR_CONFIG: reg_rdata <= config_r;
				default: reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= '0;
	end

	// Enable register gates both flag bytes bitwise
	assign irq = |(irq_en_r & (flags_a_r | flags_b_r));
	assign fault_irq_n_out = 1'b0;
	assign fault_irq_n_oe_n = !irq;

	property p_flag_sticky;
		@(posedge clock) disable iff (!resetn)
		flags_a_r[0] && !(reg_write && reg_addr == RSS_ADDR_FLAGS_A && reg_wdata[0])
		|=> flags_a_r[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag a0 lost without clear");

	property p_reset_fault;
		@(posedge clock) disable iff (!resetn)
		set_reset_pulled |=> flags_a_r[RSS_FA_RESET_PULLED];
	endproperty
	a_reset_fault: assert property (p_reset_fault)
		else $error("reset fault missed");

	property p_irq;
		@(posedge clock) disable iff (!resetn)
		(irq_en_r[0] && flags_b_r[0]) |-> !fault_irq_n_oe_n;
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq not driven");

	property p_down;
		@(posedge clock) disable iff (!resetn)
		set_emergency |=> state_r == RSS_POWER_DOWN;
	endproperty
	a_down: assert property (p_down)
		else $error("no power-down");

	property p_up;
		@(posedge clock) disable iff (!resetn)
		start_up |-> enable_out[0];
	endproperty
	a_up: assert property (p_up)
		else $error("slot 1 late");

	property p_crc;
		@(posedge clock) disable iff (!resetn)
		bus_start |=> crc_r == RSS_CHECK_INIT;
	endproperty
	a_crc: assert property (p_crc)
		else $error("check not zeroed");

	property p_extra;
		@(posedge clock) disable iff (!resetn)
		set_extra |-> !bus_write_ok ##1 flags_b_r[RSS_FB_EXTRA_BYTE];
	endproperty
	a_extra: assert property (p_extra)
		else $error("extra byte");

	property p_act;
		@(posedge clock) disable iff (!resetn)
		(start_up && !start_down && state_r == RSS_SHUTDOWN) |=> state_r == RSS_POWER_UP;
	endproperty
	a_act: assert property (p_act)
		else $error("no power-up");

	property p_fall_down;
		@(posedge clock) disable iff (!resetn)
		(!activate_in && act_r) |=> state_r == RSS_POWER_DOWN;
	endproperty
	a_fall_down: assert property (p_fall_down)
		else $error("activate fall ignored");

	property p_sleep_entry;
		@(posedge clock) disable iff (!resetn)
		(start_sleep && !start_down) |=> state_r == RSS_SLEEP_SEQ && !seq_sleep_exit_r;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep entry not started");

	property p_sleep_exit;
		@(posedge clock) disable iff (!resetn)
		(start_wake && !start_down) |=> state_r == RSS_SLEEP_SEQ && seq_sleep_exit_r;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit)
		else $error("sleep exit not started");

	property p_bad_flag;
		@(posedge clock) disable iff (!resetn)
		set_bad |=> flags_b_r[RSS_FB_BAD_CHECK];
	endproperty
	a_bad_flag: assert property (p_bad_flag)
		else $error("bad check not flagged");

endmodule

// [tb/rss_host_model.sv]
`timescale 1ns/1ns
module rss_host_model
	import rss_pkg::*;
(
	// Open-drain interrupt pin from the sequencer
	input wire logic fault_irq_n_out,
	input wire logic fault_irq_n_oe_n,
	// Converter enables
	input wire logic [RSS_NUM_OUT-1:0] enable_out,
	// What the host and the converters see
	output logic irq_pin_n,
	output logic [RSS_NUM_OUT-1:0] rail_up
);
	// Pull-up holds the line high whenever nobody pulls it down
	assign irq_pin_n = fault_irq_n_oe_n ? 1'b1 : fault_irq_n_out;
	// Converters follow their enables; start-up delay is not modelled
	assign rail_up = enable_out;
endmodule

// [tb/rss_sequencer_tb.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
	$display("Error at %0t: got %h want %h", $time, (a), (e)); end end
module rss_sequencer_tb
	import rss_pkg::*;
;
	localparam logic [51:0] UP_T = 52'h4040421642211;
	localparam logic [51:0] DN_T = 52'h4020241124415;
	localparam logic [51:0] EN_T = 52'h0010123100230;
	localparam logic [51:0] EX_T = 52'h0010431200310;
	logic clock, resetn, activate_in, sleep_in, emergency_powerdown_n, system_reset_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, bus_byte, d;
	logic reg_write, reg_read, bus_start, bus_byte_valid, bus_byte_is_check, bus_stop;
	logic bus_write_ok, shutdown_mode, sleep_mode, fault_irq_n_out, fault_irq_n_oe_n;
	logic irq_pin_n, ok;
	logic [RSS_NUM_OUT-1:0] enable_out, rail_up, up4, full, cur;
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;
	rss_sequencer dut (.clock(clock), .resetn(resetn), .activate_in(activate_in),
		.sleep_in(sleep_in), .emergency_powerdown_n(emergency_powerdown_n),
		.system_reset_n(system_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.bus_start(bus_start), .bus_byte_valid(bus_byte_valid), .bus_byte(bus_byte),
		.bus_byte_is_check(bus_byte_is_check), .bus_stop(bus_stop),
		.bus_write_ok(bus_write_ok), .enable_out(enable_out), .shutdown_mode(shutdown_mode),
		.sleep_mode(sleep_mode), .fault_irq_n_out(fault_irq_n_out),
		.fault_irq_n_oe_n(fault_irq_n_oe_n));
	rss_host_model host (.fault_irq_n_out(fault_irq_n_out),
		.fault_irq_n_oe_n(fault_irq_n_oe_n), .enable_out(enable_out),
		.irq_pin_n(irq_pin_n), .rail_up(rail_up));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	function automatic logic [12:0] smask(input logic [51:0] t, input int k);
		logic [12:0] m;
		for (int g = 0; g < RSS_NUM_OUT; g++) m[g] = t[g*4+:4] != 4'h0 && t[g*4+:4] <= k;
		return m;
	endfunction
	function automatic logic [7:0] crc8(input logic [15:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock) begin
			reg_write <= 1'b1;
			reg_addr <= a;
			reg_wdata <= v;
		end
		@(posedge clock) reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock) begin
			reg_read <= 1'b1;
			reg_addr <= a;
		end
		@(posedge clock) reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// One framed write of two bytes, check byte, optional stray byte
	task bus_txn(input logic [7:0] c, input bit extra);
		@(posedge clock) bus_start <= 1'b1;
		@(posedge clock) begin
			bus_start <= 1'b0;
			bus_byte_valid <= 1'b1;
			bus_byte <= 8'h12;
		end
		@(posedge clock) bus_byte <= 8'h34;
		@(posedge clock) begin
			bus_byte <= c;
			bus_byte_is_check <= 1'b1;
		end
		if (extra) @(posedge clock) begin
			bus_byte <= 8'h55;
			bus_byte_is_check <= 1'b0;
		end
		@(posedge clock) begin
			bus_byte_valid <= 1'b0;
			bus_byte_is_check <= 1'b0;
			bus_stop <= 1'b1;
		end
		#1 ok = bus_write_ok;
		@(posedge clock) bus_stop <= 1'b0;
	endtask
	task t_power();
		up4 = smask(UP_T, 4);
		full = smask(UP_T, 6);
		@(posedge clock) activate_in <= 1'b1;
		#1 `CHK(enable_out, smask(UP_T, 1))
		wait_n(12498);
		`CHK(enable_out, smask(UP_T, 1))
		wait_n(5);
		`CHK(enable_out, smask(UP_T, 2))
		wait_n(25000);
		`CHK(rail_up, up4)
		`CHK(shutdown_mode, 1'b0)
		wait_n(25000);
		`CHK(rail_up, full)
		rd(RSS_ADDR_STATUS);
		`CHK(d, 8'h04)
	endtask
	task t_sleep();
		@(posedge clock) sleep_in <= 1'b0;
		wait_n(3);
		`CHK(enable_out, full & ~smask(EN_T, 1))
		`CHK(sleep_mode, 1'b1)
		wait_n(12496);
		`CHK(enable_out, full & ~smask(EN_T, 1))
		wait_n(4);
		`CHK(enable_out, full & ~smask(EN_T, 2))
		@(posedge clock) sleep_in <= 1'b1;
		wait_n(3);
		cur = (full & ~smask(EN_T, 2)) | (full & smask(EX_T, 1));
		`CHK(enable_out, cur)
	endtask
	task t_down();
		@(posedge clock) begin
			emergency_powerdown_n <= 1'b0;
			activate_in <= 1'b0;
		end
		wait_n(3);
		`CHK(enable_out, cur & ~smask(DN_T, 1))
		`CHK(irq_pin_n, 1'b0)
		`CHK(shutdown_mode, 1'b1)
		wait_n(12500);
		`CHK(enable_out, cur & ~smask(DN_T, 2))
		@(posedge clock) emergency_powerdown_n <= 1'b1;
	endtask
	task t_flags();
		@(posedge clock) system_reset_n <= 1'b0;
		@(posedge clock) system_reset_n <= 1'b1;
		rd(RSS_ADDR_FLAGS_A);
		`CHK(d, 8'h03)
		wr(RSS_ADDR_FLAGS_A, 8'h00);
		rd(RSS_ADDR_FLAGS_A);
		`CHK(d, 8'h03)
		wr(RSS_ADDR_FLAGS_A, 8'h02);
		rd(RSS_ADDR_FLAGS_A);
		`CHK(d, 8'h01)
		`CHK(irq_pin_n, 1'b0)
		wr(RSS_ADDR_IRQ_EN, 8'h00);
		wait_n(2);
		`CHK(irq_pin_n, 1'b1)
		wr(RSS_ADDR_IRQ_EN, 8'hff);
		wr(RSS_ADDR_FLAGS_A, 8'h01);
		rd(RSS_ADDR_FLAGS_A);
		`CHK(d, 8'h00)
		`CHK(irq_pin_n, 1'b1)
		rd(8'h10);
		`CHK(d, 8'h00)
	endtask
	task t_check();
		bus_txn(crc8(16'h1234) ^ 8'hff, 1'b0);
		rd(RSS_ADDR_FLAGS_B);
		`CHK(d, 8'h00)
		bus_txn(crc8(16'h1234), 1'b0);
		`CHK(ok, 1'b1)
		rd(RSS_ADDR_FLAGS_B);
		`CHK(d, 8'h01)
		bus_txn(crc8(16'h1234), 1'b1);
		`CHK(ok, 1'b0)
		rd(RSS_ADDR_FLAGS_B);
		`CHK(d, 8'h03)
	endtask
	task print_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Whole run needs about 87600 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 95000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		{resetn, activate_in, reg_write, reg_read, bus_start, bus_stop} = '0;
		{bus_byte_valid, bus_byte_is_check, reg_addr, reg_wdata, bus_byte} = '0;
		{sleep_in, emergency_powerdown_n, system_reset_n} = 3'b111;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		#1 `CHK({enable_out, fault_irq_n_oe_n, shutdown_mode}, 15'h0003)
		rd(RSS_ADDR_IRQ_EN);
		`CHK(d, 8'hff)
		rd(RSS_ADDR_CONFIG);
		`CHK(d, 8'h01)
		t_power();
		t_sleep();
		t_down();
		t_flags();
		t_check();
		print_verdict();
	end
endmodule
